// File: design/pie_pkg.sv
package pie_pkg;
    // Register byte offsets on the AXI4-Lite bus
    localparam logic [3:0] OFS_ENABLE_A = 4'h0;
    localparam logic [3:0] OFS_ENABLE_B = 4'h4;
    localparam logic [3:0] OFS_FLAGS_A = 4'h8;
    localparam logic [3:0] OFS_FLAGS_B = 4'hC;
    localparam logic [3:0] OFS_CORE_CTRL = 4'h0 + 4'h0;
    localparam logic [3:0] OFS_CORE_CTRL_REG = 4'hC + 4'h0;
    localparam int ADDR_W = 5;
    localparam logic [4:0] OFS_CORE = 5'h10;
    // Reset values
    localparam logic [7:0] RST_ENABLE_A = 8'h00;
    localparam logic [7:0] RST_FLAGS_A = 8'h00;
    localparam logic RST_BIT = 1'h0;
    // Bit positions in the flag and enable bytes
    localparam int BIT_GATE = 7;
    localparam int BIT_ADC = 6;
    localparam int BIT_RX = 5;
    localparam int BIT_TX = 4;
    localparam int BIT_SYNC = 3;
    localparam int BIT_CAP1 = 2;
    localparam int BIT_PERIOD = 1;
    localparam int BIT_OVF = 0;
    localparam int BIT_CAP2 = 0;
    // Core control bit positions
    localparam int BIT_GLOBAL_EN = 7;
    localparam int BIT_PERIPH_EN = 6;
    // Bits of flags_a that software may write
    localparam logic [7:0] FLAGS_A_WMASK = 8'hCF;
    // Capture unit modes
    localparam logic [1:0] MODE_CAPTURE = 2'h0;
    localparam logic [1:0] MODE_COMPARE = 2'h1;
    localparam logic [1:0] MODE_PWM = 2'h2;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : pie_pkg

// File: design/pie_bank.sv
// Contract
// - Peripheral requests need peripheral enable set
// - Flags set regardless of any enable
// - Enable A holds eight writable enables
// - Enable B only bit 0, rest zero
// - Flags A order; rx, tx read-only
// - Gate flag shows 1 when gate inactive
// - ADC flag sticky on conversion done
// - Rx flag follows full; cleared by read
// - Tx flag follows empty; cleared by write
// - Sync port flag sticky on done
// - Capture 1 flag by mode, not PWM
// - Period match flag sticky
// - Overflow flag sticky
// - Capture 2 flag bit 0 only
// - Nothing forwarded while global enable clear
`timescale 1ns/1ps
module pie_bank
    import pie_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [4:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [4:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Peripheral event inputs, one-cycle pulses or levels
    input wire logic gate_active,
    input wire logic adc_done,
    input wire logic rx_buffer_full,
    input wire logic tx_buffer_empty,
    input wire logic sync_port_done,
    input wire logic [1:0] capcmp_one_mode,
    input wire logic capcmp_one_capture,
    input wire logic capcmp_one_match,
    input wire logic [1:0] capcmp_two_mode,
    input wire logic capcmp_two_capture,
    input wire logic capcmp_two_match,
    input wire logic period_match,
    input wire logic count_overflow,
    // Side effects of data register access
    input wire logic serial_rx_data_read,
    input wire logic serial_tx_data_write,
    // Core interrupt control bits
    input wire logic global_irq_en,
    input wire logic peripheral_irq_master_en,
    // Request to the core
    output logic periph_irq_req
);
    // Registers
    logic [7:0] peripheral_irq_enable_a;
    logic capcmp_two_irq_en;
    logic gate_acq_flag;
    logic adc_done_flag;
    logic serial_rx_full_flag;
    logic serial_tx_empty_flag;
    logic sync_port_done_flag;
    logic capcmp_one_flag;
    logic period_match_flag;
    logic overflow_flag;
    logic capcmp_two_flag;
    logic [7:0] flags_a;
    logic [4:0] aw_addr;
    logic aw_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic w_held;
    logic do_write;
    logic wr_ena;
    logic wr_enb;
    logic wr_fa;
    logic wr_fb;
    logic cap1_event;
    logic cap2_event;
    logic wr_mapped;
    logic [7:0] flag_wr_data;

    // Write address and data captured independently, response after both
    assign do_write = aw_held && w_held && !s_axi_bvalid;
    assign wr_ena = do_write && w_strb[0] && aw_addr == {1'b0, OFS_ENABLE_A};
    assign wr_enb = do_write && w_strb[0] && aw_addr == {1'b0, OFS_ENABLE_B};
    assign wr_fa = do_write && w_strb[0] && aw_addr == {1'b0, OFS_FLAGS_A};
    assign wr_fb = do_write && w_strb[0] && aw_addr == {1'b0, OFS_FLAGS_B};

    // Only the four byte-wide registers answer OKAY; refused writes touch nothing
    assign wr_mapped = aw_addr == {1'b0, OFS_ENABLE_A} || aw_addr == {1'b0, OFS_ENABLE_B} ||
                       aw_addr == {1'b0, OFS_FLAGS_A} || aw_addr == {1'b0, OFS_FLAGS_B};

    // Serial status bits are masked out here so software can never reach them
    assign flag_wr_data = w_data[7:0] & FLAGS_A_WMASK;

    // Write address channel
    // Ready is a one-cycle pulse so a held valid is taken exactly once;
    // a second address waits until the pending write has been answered
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
            s_axi_awready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (do_write) begin
                aw_held <= 1'b0;
            end
        end
    end

    // Write data channel
    // Same scheme as the address side; either channel may arrive first
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (do_write) begin
                w_held <= 1'b0;
            end
        end
    end

    // Write response; unmapped addresses answer SLVERR
    // A refused write is still answered so the master never hangs on it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            peripheral_irq_enable_a <= RST_ENABLE_A;
        end else if (wr_ena) begin
            peripheral_irq_enable_a <= w_data[7:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            capcmp_two_irq_en <= RST_BIT;
        end else if (wr_enb) begin
            capcmp_two_irq_en <= w_data[BIT_CAP2];
        end
    end

    // Strobes of the function not selected are ignored; mode 3 decodes like PWM
    // and raises nothing, so a stray code cannot leave a flag pending
    // mode selects the event; PWM gives none
    assign cap1_event = (capcmp_one_mode == MODE_CAPTURE && capcmp_one_capture) ||
                        (capcmp_one_mode == MODE_COMPARE && capcmp_one_match);
    assign cap2_event = (capcmp_two_mode == MODE_CAPTURE && capcmp_two_capture) ||
                        (capcmp_two_mode == MODE_COMPARE && capcmp_two_match);

    // Sticky flags; a hardware set wins over a same-cycle software clear
    // set ignores enables
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            adc_done_flag <= RST_BIT;
            sync_port_done_flag <= RST_BIT;
            capcmp_one_flag <= RST_BIT;
            period_match_flag <= RST_BIT;
            overflow_flag <= RST_BIT;
        end else begin
            adc_done_flag <= adc_done || (wr_fa ? flag_wr_data[BIT_ADC] : adc_done_flag);
            sync_port_done_flag <= sync_port_done ||
                (wr_fa ? flag_wr_data[BIT_SYNC] : sync_port_done_flag);
            capcmp_one_flag <= cap1_event || (wr_fa ? flag_wr_data[BIT_CAP1] : capcmp_one_flag);
            period_match_flag <= period_match ||
                (wr_fa ? flag_wr_data[BIT_PERIOD] : period_match_flag);
            overflow_flag <= count_overflow || (wr_fa ? flag_wr_data[BIT_OVF] : overflow_flag);
        end
    end

    // Capture unit two flag
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            capcmp_two_flag <= RST_BIT;
        end else begin
            capcmp_two_flag <= cap2_event || (wr_fb ? w_data[BIT_CAP2] : capcmp_two_flag);
        end
    end

    // Gate flag tracks the gate; a software write may force it to one for one cycle
    // Limitation: a forced one lasts a single cycle, then the live gate level wins
    // inactive reads one
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gate_acq_flag <= RST_BIT;
        end else if (wr_fa) begin
            gate_acq_flag <= flag_wr_data[BIT_GATE] || !gate_active;
        end else begin
            gate_acq_flag <= !gate_active;
        end
    end

    // Serial status flags are live levels, read-only to software
    // The forced zero lasts one cycle only; a buffer that stays full
    // raises the flag again on the next edge
    // rx follows buffer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            serial_rx_full_flag <= RST_BIT;
            serial_tx_empty_flag <= RST_BIT;
        end else begin
            serial_rx_full_flag <= rx_buffer_full && !serial_rx_data_read;
            serial_tx_empty_flag <= tx_buffer_empty && !serial_tx_data_write;
        end
    end

    assign flags_a = {gate_acq_flag, adc_done_flag, serial_rx_full_flag,
                      serial_tx_empty_flag, sync_port_done_flag, capcmp_one_flag,
                      period_match_flag, overflow_flag};

    // Read channel, one read at a time
    // Data is taken from the flags at the address handshake; a level flag that
    // moves while the answer waits shows only on the next read
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= RESP_OKAY;
                s_axi_rdata <= '0;
                case (s_axi_araddr)
                    {1'b0, OFS_ENABLE_A}: s_axi_rdata[7:0] <= peripheral_irq_enable_a;
                    {1'b0, OFS_ENABLE_B}: s_axi_rdata[BIT_CAP2] <= capcmp_two_irq_en;
                    {1'b0, OFS_FLAGS_A}: s_axi_rdata[7:0] <= flags_a;
                    {1'b0, OFS_FLAGS_B}: s_axi_rdata[BIT_CAP2] <= capcmp_two_flag;
                    default: s_axi_rresp <= RESP_SLVERR;
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Request to the core, registered
    // Leaving a flip-flop costs one edge of latency but keeps the core glitch free
    // flag and enable OR
    // stale flags fire when enabled, so software clears first
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            periph_irq_req <= 1'b0;
        end else begin
            periph_irq_req <= global_irq_en && peripheral_irq_master_en &&
                ((|(flags_a & peripheral_irq_enable_a)) ||
                 (capcmp_two_flag && capcmp_two_irq_en));
        end
    end
endmodule : pie_bank

// File: bench/pie_bank_assertions.sv
`timescale 1ns/1ps
module pie_bank_assertions
    import pie_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Watched bus signals
    input wire logic [4:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // Core enables and request
    input wire logic global_irq_en,
    input wire logic peripheral_irq_master_en,
    input wire logic periph_irq_req
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Read address taken this edge
    logic ar_hs;
    assign ar_hs = s_axi_arvalid && s_axi_arready;
    periph_gate_a: assert property (!$past(peripheral_irq_master_en) |-> !periph_irq_req)
        else $error("request without peripheral enable");
    global_gate_a: assert property (!$past(global_irq_en) |-> !periph_irq_req)
        else $error("request without global enable");
    rd_okay_a: assert property (ar_hs && !s_axi_araddr[4] && s_axi_araddr[1:0] == 2'h0
        |=> s_axi_rvalid && s_axi_rresp == RESP_OKAY) else $error("mapped read not okay");
    rd_refused_a: assert property (ar_hs && (s_axi_araddr[4] || s_axi_araddr[1:0] != 2'h0)
        |=> s_axi_rvalid && s_axi_rresp == RESP_SLVERR) else $error("unmapped read accepted");
    enb_upper_a: assert property (ar_hs && s_axi_araddr == {1'h0, OFS_ENABLE_B}
        |=> s_axi_rdata[7:1] == 7'h00) else $error("enable b upper bits set");
    flb_upper_a: assert property (ar_hs && s_axi_araddr == {1'h0, OFS_FLAGS_B}
        |=> s_axi_rdata[7:1] == 7'h00) else $error("flags b upper bits set");
    rd_word_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read answer dropped");
    wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped");
    // Main scenarios reached
    cover property (periph_irq_req);
    cover property (ar_hs && s_axi_araddr[4]);
    cover property (s_axi_bvalid && s_axi_bready);
endmodule : pie_bank_assertions

bind pie_bank pie_bank_assertions i_chk (.*);

// File: bench/pie_periph_model.sv
`timescale 1ns/1ps
module pie_periph_model (
    // Clock and command from the bench
    input wire logic aclk,
    input wire logic fire,
    input wire logic [2:0] sel,
    // One-cycle peripheral events
    output logic [7:0] ev = 8'h00
);
    // One event per command, one cycle wide, so each sticky flag has a single cause
    always @(posedge aclk) begin
        ev <= fire ? (8'h01 << sel) : 8'h00;
    end
endmodule : pie_periph_model

// File: bench/pie_bank_tb.sv
`timescale 1ns/1ps
module pie_bank_tb;
    import pie_pkg::*;
    // Bus, level and event signals
    logic aclk = 1'h0, aresetn = 1'h0, fire = 1'h0, periph_irq_req;
    logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, capcmp_one_mode = 2'h0, capcmp_two_mode = 2'h0;
    logic gate_active = 1'h1, rx_buffer_full = 1'h0, tx_buffer_empty = 1'h0;
    logic serial_rx_data_read = 1'h0, serial_tx_data_write = 1'h0;
    logic global_irq_en = 1'h0, peripheral_irq_master_en = 1'h0;
    logic [2:0] sel = 3'h0;
    logic [7:0] ev, fa = 8'h00, fb = 8'h00, ea = 8'h00, eb = 8'h00;
    logic adc_done, sync_port_done, period_match, count_overflow;
    logic capcmp_one_capture, capcmp_one_match, capcmp_two_capture, capcmp_two_match;
    int fail_count = 0, cmp_count = 0, seed = 32;
    localparam logic [4:0] EA = {1'h0, OFS_ENABLE_A}, EB = {1'h0, OFS_ENABLE_B};
    localparam logic [4:0] FA = {1'h0, OFS_FLAGS_A}, FB = {1'h0, OFS_FLAGS_B};
    assign {capcmp_two_match, capcmp_two_capture, adc_done, sync_port_done} = ev[7:4];
    assign {capcmp_one_match, capcmp_one_capture, period_match, count_overflow} = ev[3:0];
    pie_periph_model i_per (.aclk, .fire, .sel, .ev);
    pie_bank i_dut (.*);
    // Free running 40 MHz clock
    initial begin
        forever #12.5 aclk = ~aclk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic test_done();
        $display("mismatches=%0d compares=%0d", fail_count, cmp_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : test_done
    // Reference view; bits 7, 5 and 4 of flags a follow their levels
    function automatic logic [31:0] rexp(input logic [4:0] a);
        case (a)
            EA: return {24'h0, ea};
            EB: return {24'h0, eb};
            FA: return {24'h0, ~gate_active, fa[6], rx_buffer_full, tx_buffer_empty, fa[3:0]};
            default: return {24'h0, fb};
        endcase
    endfunction : rexp
    // Request expected from the model flags, enables and core gates
    function automatic logic [31:0] iexp();
        logic [31:0] f;
        f = rexp(FA) & {24'h0, ea};
        return {31'h0, global_irq_en && peripheral_irq_master_en && (|f || (fb[0] && eb[0]))};
    endfunction : iexp
    // Bus master: offer both channels, release each once taken
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [1:0] resp;
        resp = (a == EA || a == EB || a == FA || a == FB) ? RESP_OKAY : RESP_SLVERR;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
        chk({30'h0, s_axi_bresp}, {30'h0, resp});
        // An edge passes so the next call never re-raises bready in this step
        @(posedge aclk);
    endtask : wr
    task automatic rd(input logic [4:0] a, input logic [1:0] resp);
        logic [31:0] exp;
        exp = rexp(a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
        chk({30'h0, s_axi_rresp}, {30'h0, resp});
        if (resp == RESP_OKAY) chk(s_axi_rdata, exp);
        @(posedge aclk);
    endtask : rd
    // One peripheral event; capture units count only in their own mode
    task automatic kick(input int e);
        sel <= e[2:0];
        fire <= 1'h1;
        @(posedge aclk);
        fire <= 1'h0;
        repeat (3) @(posedge aclk);
        case (e)
            0, 1: fa[e] = 1'h1;
            2, 3: if (capcmp_one_mode == e - 2) fa[2] = 1'h1;
            4: fa[3] = 1'h1;
            5: fa[6] = 1'h1;
            default: if (capcmp_two_mode == e - 6) fb[0] = 1'h1;
        endcase
    endtask : kick
    // Watchdog well beyond the expected few hundred cycles
    initial begin
        #500000;
        fail_count++;
        test_done();
    end
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        // Reset values, unaligned and unmapped reads
        for (int a = 0; a < 24; a += 2) begin
            rd(a[4:0], (a < 16 && a % 4 == 0) ? RESP_OKAY : RESP_SLVERR);
        end
        ea = 8'($random(seed));
        eb = 8'h01;
        wr(EA, {24'h0, ea});
        wr(EB, 32'hFF);
        wr(5'h12, 32'hFF);
        rd(EA, RESP_OKAY);
        rd(EB, RESP_OKAY);
        // A write without byte lane 0 leaves the register alone
        s_axi_wstrb <= 4'hE;
        wr(EA, ~{24'h0, ea});
        s_axi_wstrb <= 4'hF;
        rd(EA, RESP_OKAY);
        fa = 8'($random(seed)) & 8'h4F;
        wr(FA, {24'h0, fa});
        rd(FA, RESP_OKAY);
        // Every source in every capture unit mode
        for (int m = 0; m < 3; m++) begin
            capcmp_one_mode <= m[1:0];
            capcmp_two_mode <= m[1:0];
            wr(FA, 32'h0);
            wr(FB, 32'h0);
            fa = 8'h00;
            fb = 8'h00;
            for (int e = 0; e < 8; e++) begin
                kick(e);
                rd(FA, RESP_OKAY);
                rd(FB, RESP_OKAY);
            end
        end
        // Level flags follow their sources; a software write of zero does not clear them
        gate_active <= 1'h0;
        rx_buffer_full <= 1'h1;
        tx_buffer_empty <= 1'h1;
        wr(FA, 32'h0);
        fa = 8'h00;
        rd(FA, RESP_OKAY);
        serial_rx_data_read <= 1'h1;
        serial_tx_data_write <= 1'h1;
        rx_buffer_full <= 1'h0;
        tx_buffer_empty <= 1'h0;
        @(posedge aclk);
        serial_rx_data_read <= 1'h0;
        serial_tx_data_write <= 1'h0;
        gate_active <= 1'h1;
        repeat (2) @(posedge aclk);
        rd(FA, RESP_OKAY);
        wr(FA, 32'h0);
        wr(EA, 32'h01);
        fa = 8'h00;
        ea = 8'h01;
        kick(0);
        for (int g = 0; g < 4; g++) begin
            global_irq_en <= g[1];
            peripheral_irq_master_en <= g[0];
            repeat (3) @(posedge aclk);
            chk({31'h0, periph_irq_req}, iexp());
        end
        wr(EA, 32'h0);
        ea = 8'h00;
        repeat (3) @(posedge aclk);
        chk({31'h0, periph_irq_req}, 32'h0);
        wr(FB, 32'h01);
        fb = 8'h01;
        repeat (3) @(posedge aclk);
        chk({31'h0, periph_irq_req}, 32'h1);
        test_done();
    end
endmodule : pie_bank_tb
